//--- hw/wcu_pkg.sv
// Shared register map, field positions, reset patterns and timing constants of the watchdog unit.
package wcu_pkg;

	// ----------------------------------------------------------------------
	// Register byte addresses on the AXI4-Lite bus.
	// ----------------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_WD_CTRL = 12'h0D8; // Watchdog control and status.
	localparam logic [11:0] ADDR_INT_EN = 12'h0E8; // Extended interrupt enable.
	localparam logic [11:0] ADDR_INT_PRIO = 12'h0F8; // Extended interrupt priority.
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h100; // Sticky event bits, write one to clear.
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h104; // Event mask, one lets the event through.

	// ----------------------------------------------------------------------
	// Field positions inside the control and status register.
	// ----------------------------------------------------------------------
	localparam int BIT_BAUD2 = 7; // Second serial port baud doubling.
	localparam int BIT_POR = 6; // Power-on flag.
	localparam int BIT_INT_FLAG = 3; // Watchdog interrupt flag.
	localparam int BIT_RST_FLAG = 2; // Watchdog reset flag.
	localparam int BIT_RST_EN = 1; // Watchdog reset enable.
	localparam int BIT_RESTART = 0; // Watchdog restart, self clearing.

	// Bits that an external reset leaves alone; every other bit goes to zero.
	localparam logic [7:0] EXT_RESET_KEEP = 8'h56;

	// ----------------------------------------------------------------------
	// Interrupt enable, priority and event fields.
	// ----------------------------------------------------------------------
	localparam int BIT_WD_INT_EN = 4; // Watchdog interrupt enable.
	localparam int BIT_WD_INT_PRIO = 4; // Watchdog interrupt priority.
	localparam logic [7:0] INT_EN_RSVD_ONES = 8'hE0; // Reserved enable bits read high.
	localparam int NUM_EXT_INT = 4; // External interrupts two to five.
	localparam int NUM_EVENTS = 2;
	localparam int EV_TIMEOUT = 0; // Watchdog time-out elapsed.
	localparam int EV_WDRESET = 1; // Watchdog reset issued.

	// ----------------------------------------------------------------------
	// Timing and bus answers.
	// ----------------------------------------------------------------------
	localparam int RESET_DELAY_CLOCKS = 512; // Clocks from time-out to watchdog reset.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Counter phases of the watchdog.
	typedef enum logic [0:0] {
		WCU_COUNTING,
		WCU_DELAYING
	} wcu_phase_t;

endpackage

//--- hw/wcu_counter.sv
// Watchdog interval counter with the post time-out reset delay.
`timescale 1ns/1ps
module wcu_counter #(
	parameter int TIMEOUT_CYCLES = 131072,
	parameter int DELAY_CYCLES = wcu_pkg::RESET_DELAY_CLOCKS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic restart,
	input wire logic reset_enable,
	output logic timeout_pulse,
	output logic reset_pulse
);

	// ----------------------------------------------------------------------
	// Elaboration checks.
	// ----------------------------------------------------------------------
	if (TIMEOUT_CYCLES < 2 || DELAY_CYCLES < 2) begin : g_bad_count
		$error("wcu_counter: counts must be at least two");
	end

	localparam int CW = $clog2(TIMEOUT_CYCLES > DELAY_CYCLES ? TIMEOUT_CYCLES : DELAY_CYCLES) + 1;
	localparam logic [CW-1:0] TIMEOUT_LAST = CW'(TIMEOUT_CYCLES - 1);
	localparam logic [CW-1:0] DELAY_LAST = CW'(DELAY_CYCLES - 1);

	wcu_pkg::wcu_phase_t phase_r; // Interval or reset delay.
	logic [CW-1:0] count_r; // Cycles spent in the current phase.

	// ----------------------------------------------------------------------
	// Count every clock; a restart always returns to a clean interval.
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		timeout_pulse <= 1'b0;
		reset_pulse <= 1'b0;
		if (!aresetn || restart) begin
			phase_r <= wcu_pkg::WCU_COUNTING;
			count_r <= '0;
		end else begin
			unique case (phase_r)
				wcu_pkg::WCU_COUNTING: begin
					// Advances on every system clock.
					if (count_r == TIMEOUT_LAST) begin
						timeout_pulse <= 1'b1;
						phase_r <= wcu_pkg::WCU_DELAYING;
						count_r <= '0;
					end else begin
						count_r <= count_r + 1'b1;
					end
				end
				wcu_pkg::WCU_DELAYING: begin
					// Without the enable the delay just ends and a new interval starts.
					if (count_r == DELAY_LAST) begin
						reset_pulse <= reset_enable;
						phase_r <= wcu_pkg::WCU_COUNTING;
						count_r <= '0;
					end else begin
						count_r <= count_r + 1'b1;
					end
				end
			endcase
		end
	end

endmodule

//--- hw/wcu_axil_slave.sv
// AXI4-Lite slave front end that turns bus beats into single-cycle register strobes.
`timescale 1ns/1ps
module wcu_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_en,
	output logic [11:0] wr_addr,
	output logic [7:0] wr_data,
	input wire logic wr_hit,
	output logic [11:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic rd_hit
);

	logic aw_held_r; // Write address taken, waiting for data.
	logic w_held_r; // Write data taken, waiting for address.
	logic rd_pend_r; // Read address taken, data sampled next cycle.

	// ----------------------------------------------------------------------
	// Write path: address and data in either order, then one strobe, then B.
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		wr_en <= 1'b0;
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			bvalid <= 1'b0;
			bresp <= wcu_pkg::RESP_OKAY;
			wr_addr <= '0;
			wr_data <= '0;
		end else begin
			awready <= !aw_held_r && !awready && !bvalid && !wr_en;
			wready <= !w_held_r && !wready && !bvalid && !wr_en;
			if (awvalid && awready) begin
				aw_held_r <= 1'b1;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_held_r <= 1'b1;
				wr_data <= wdata[7:0];
				// A beat without the low lane carries nothing for these registers.
				if (!wstrb[0]) begin
					wr_data <= '0;
				end
			end
			if (aw_held_r && w_held_r && !wr_en && !bvalid) begin
				wr_en <= 1'b1;
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
			end
			if (wr_en) begin
				bvalid <= 1'b1;
				bresp <= wr_hit ? wcu_pkg::RESP_OKAY : wcu_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Read path: take the address, sample the register the cycle after.
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rd_pend_r <= 1'b0;
			rd_addr <= '0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= wcu_pkg::RESP_OKAY;
		end else begin
			arready <= !arready && !rd_pend_r && !rvalid;
			rd_pend_r <= 1'b0;
			if (arvalid && arready) begin
				rd_addr <= araddr;
				rd_pend_r <= 1'b1;
			end
			if (rd_pend_r) begin
				rvalid <= 1'b1;
				rdata <= {24'h000000, rd_data};
				rresp <= rd_hit ? wcu_pkg::RESP_OKAY : wcu_pkg::RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

endmodule

//--- hw/wcu_top.sv
// Watchdog control unit: control register, interrupt enable and priority, reset sources.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module wcu_top #(
	parameter int TIMEOUT_CYCLES = 131072 // Watchdog interval in clocks.
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic ext_reset_req, // External reset pin event, one cycle.
	input wire logic power_fail_req, // Power-down reset event, one cycle.
	input wire logic timed_access_grant, // Permission for the next register write.
	input wire logic [1:0] serial2_mode, // Current mode of the second serial port.
	output logic baud_double_active,
	output logic wdt_sys_reset,
	output logic wdt_int_req,
	output logic wdt_int_high_prio,
	output logic [3:0] ext_int_enable,
	output logic [3:0] ext_int_high_prio,
	output logic irq
);

	// ----------------------------------------------------------------------
	// Elaboration checks.
	// ----------------------------------------------------------------------
	if (TIMEOUT_CYCLES < 2) begin : g_bad_timeout
		$error("wcu_top: TIMEOUT_CYCLES must be at least two");
	end

	// ----------------------------------------------------------------------
	// Register state.
	// ----------------------------------------------------------------------
	logic baud2_r; // Second port baud doubling.
	logic por_r; // Power-on flag.
	logic int_flag_r; // Watchdog interrupt flag.
	logic rst_flag_r; // Watchdog reset flag.
	logic rst_en_r; // Watchdog reset enable.
	logic restart_r; // Restart request, lives for one cycle.
	logic wd_int_en_r; // Watchdog interrupt enable.
	logic [3:0] ex_en_r; // External interrupt enables.
	logic wd_prio_r; // Watchdog interrupt priority.
	logic [3:0] px_r; // External interrupt priorities.
	logic [1:0] ev_status_r; // Sticky event bits.
	logic [1:0] ev_mask_r; // Event mask.
	logic ta_open_r; // Timed access window for one write.

	// ----------------------------------------------------------------------
	// Bus strobes from the slave front end.
	// ----------------------------------------------------------------------
	logic wr_en;
	logic [11:0] wr_addr;
	logic [7:0] wr_data;
	logic [11:0] rd_addr;
	logic [7:0] rd_data;
	logic wr_hit;
	logic rd_hit;

	// Watchdog events.
	logic timeout_pulse;
	logic wd_reset_pulse;

	// Decoded write enables.
	logic wr_ctrl;
	logic wr_prot;

	// ----------------------------------------------------------------------
	// Shared helpers.
	// ----------------------------------------------------------------------

	// True where an address names a register of this block.
	function automatic logic addr_mapped(input logic [11:0] a);
		addr_mapped = (a == wcu_pkg::ADDR_WD_CTRL) || (a == wcu_pkg::ADDR_INT_EN) ||
			(a == wcu_pkg::ADDR_INT_PRIO) || (a == wcu_pkg::ADDR_IRQ_STATUS) ||
			(a == wcu_pkg::ADDR_IRQ_MASK);
	endfunction

	// Next value of a hardware-set, software-written flag; the set wins.
	function automatic logic flag_next(input logic cur, input logic set,
			input logic wr, input logic val);
		if (set) begin
			flag_next = 1'b1;
		end else if (wr) begin
			flag_next = val;
		end else begin
			flag_next = cur;
		end
	endfunction

	assign wr_hit = addr_mapped(wr_addr);
	assign rd_hit = addr_mapped(rd_addr);
	assign wr_ctrl = wr_en && (wr_addr == wcu_pkg::ADDR_WD_CTRL);
	// Protected bits only move while the timed access window is open.
	assign wr_prot = wr_ctrl && ta_open_r;

	// ----------------------------------------------------------------------
	// Sub-blocks.
	// ----------------------------------------------------------------------
	wcu_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_hit(wr_hit),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// An external reset also puts the counter into a known state.
	wcu_counter #(
		.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
		.DELAY_CYCLES(wcu_pkg::RESET_DELAY_CLOCKS)
	) u_count (
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(restart_r || ext_reset_req || wdt_sys_reset),
		.reset_enable(rst_en_r),
		.timeout_pulse(timeout_pulse),
		.reset_pulse(wd_reset_pulse)
	);

	// ----------------------------------------------------------------------
	// Timed access window: opened by the grant, spent by the next write.
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ta_open_r <= 1'b0;
		end else if (timed_access_grant) begin
			ta_open_r <= 1'b1;
		end else if (wr_en) begin
			// Any write, mapped or not, uses up the permission.
			ta_open_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// Power-on flag and reset enable, both protected.
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_r <= 1'b1;
			rst_en_r <= 1'b0;
		end else if (wr_prot) begin
			// External and watchdog resets leave both bits alone.
			por_r <= wr_data[wcu_pkg::BIT_POR];
			rst_en_r <= wr_data[wcu_pkg::BIT_RST_EN];
		end
	end

	// ----------------------------------------------------------------------
	// Baud doubling bit, freely writable, cleared by an external reset.
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || ext_reset_req) begin
			baud2_r <= 1'b0;
		end else if (wr_ctrl) begin
			baud2_r <= wr_data[wcu_pkg::BIT_BAUD2];
		end
	end

	// ----------------------------------------------------------------------
	// Interrupt flag: set by time-out, cleared by a protected write or an external reset.
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_flag_r <= 1'b0;
		end else if (ext_reset_req && !timeout_pulse) begin
			int_flag_r <= 1'b0;
		end else begin
			// Set regardless of the enable, so software can poll the time-out.
			int_flag_r <= flag_next(int_flag_r, timeout_pulse, wr_prot,
				wr_data[wcu_pkg::BIT_INT_FLAG]);
		end
	end

	// ----------------------------------------------------------------------
	// Reset flag: freely writable, set by a watchdog reset, cleared by power.
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || power_fail_req) begin
			rst_flag_r <= 1'b0;
		end else begin
			// The reset pulse only exists with the enable set, so nothing else
			// of the watchdog can touch this flag. An external reset is ignored.
			rst_flag_r <= flag_next(rst_flag_r, wd_reset_pulse && rst_en_r, wr_ctrl,
				wr_data[wcu_pkg::BIT_RST_FLAG]);
		end
	end

	// ----------------------------------------------------------------------
	// Restart bit: a protected write of one lives for a single cycle.
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || ext_reset_req) begin
			// An external reset loads a zero here as well.
			restart_r <= 1'b0;
		end else begin
			restart_r <= wr_prot && wr_data[wcu_pkg::BIT_RESTART];
		end
	end

	// ----------------------------------------------------------------------
	// Extended interrupt enable and priority registers.
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wd_int_en_r <= 1'b0;
			ex_en_r <= '0;
			wd_prio_r <= 1'b0;
			px_r <= '0;
		end else if (wr_en) begin
			if (wr_addr == wcu_pkg::ADDR_INT_EN) begin
				wd_int_en_r <= wr_data[wcu_pkg::BIT_WD_INT_EN];
				ex_en_r <= wr_data[wcu_pkg::NUM_EXT_INT-1:0];
			end
			if (wr_addr == wcu_pkg::ADDR_INT_PRIO) begin
				wd_prio_r <= wr_data[wcu_pkg::BIT_WD_INT_PRIO];
				px_r <= wr_data[wcu_pkg::NUM_EXT_INT-1:0];
			end
		end
	end

	// ----------------------------------------------------------------------
	// Event status (write one to clear, set wins) and mask.
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_status_r <= '0;
			ev_mask_r <= '0;
		end else begin
			for (int i = 0; i < wcu_pkg::NUM_EVENTS; i++) begin
				if (wr_en && wr_addr == wcu_pkg::ADDR_IRQ_STATUS && wr_data[i]) begin
					ev_status_r[i] <= 1'b0;
				end
			end
			if (timeout_pulse) begin
				ev_status_r[wcu_pkg::EV_TIMEOUT] <= 1'b1;
			end
			if (wd_reset_pulse) begin
				ev_status_r[wcu_pkg::EV_WDRESET] <= 1'b1;
			end
			if (wr_en && wr_addr == wcu_pkg::ADDR_IRQ_MASK) begin
				ev_mask_r <= wr_data[wcu_pkg::NUM_EVENTS-1:0];
			end
		end
	end

	// ----------------------------------------------------------------------
	// Read multiplexer; the bus slave samples it one cycle after the address.
	// ----------------------------------------------------------------------
	always_comb begin
		rd_data = 8'h00;
		if (rd_addr == wcu_pkg::ADDR_WD_CTRL) begin
			// Every control bit reads back freely.
			rd_data[wcu_pkg::BIT_BAUD2] = baud2_r;
			rd_data[wcu_pkg::BIT_POR] = por_r;
			rd_data[wcu_pkg::BIT_INT_FLAG] = int_flag_r;
			rd_data[wcu_pkg::BIT_RST_FLAG] = rst_flag_r;
			rd_data[wcu_pkg::BIT_RST_EN] = rst_en_r;
			rd_data[wcu_pkg::BIT_RESTART] = restart_r;
		end else if (rd_addr == wcu_pkg::ADDR_INT_EN) begin
			rd_data = wcu_pkg::INT_EN_RSVD_ONES;
			rd_data[wcu_pkg::BIT_WD_INT_EN] = wd_int_en_r;
			rd_data[wcu_pkg::NUM_EXT_INT-1:0] = ex_en_r;
		end else if (rd_addr == wcu_pkg::ADDR_INT_PRIO) begin
			rd_data[wcu_pkg::BIT_WD_INT_PRIO] = wd_prio_r;
			rd_data[wcu_pkg::NUM_EXT_INT-1:0] = px_r;
		end else if (rd_addr == wcu_pkg::ADDR_IRQ_STATUS) begin
			rd_data[wcu_pkg::NUM_EVENTS-1:0] = ev_status_r;
		end else if (rd_addr == wcu_pkg::ADDR_IRQ_MASK) begin
			rd_data[wcu_pkg::NUM_EVENTS-1:0] = ev_mask_r;
		end
	end

	// ----------------------------------------------------------------------
	// Registered outputs toward the core, the serial port and the system.
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			baud_double_active <= 1'b0;
			wdt_sys_reset <= 1'b0;
			wdt_int_req <= 1'b0;
			wdt_int_high_prio <= 1'b0;
			ext_int_enable <= '0;
			ext_int_high_prio <= '0;
			irq <= 1'b0;
		end else begin
			// Mode zero runs at a fixed rate and is not doubled.
			baud_double_active <= baud2_r && (serial2_mode != 2'h0);
			wdt_sys_reset <= wd_reset_pulse;
			wdt_int_req <= int_flag_r && wd_int_en_r;
			wdt_int_high_prio <= wd_prio_r;
			ext_int_enable <= ex_en_r;
			ext_int_high_prio <= px_r;
			irq <= |(ev_status_r & ev_mask_r);
		end
	end

endmodule

//--- verification/wcu_properties.sv
// Port-level checks of the watchdog unit, bound to its top module.
`timescale 1ns/1ps
module wcu_chk (
	input logic aclk,
	input logic aresetn,
	input logic awvalid,
	input logic awready,
	input logic wvalid,
	input logic wready,
	input logic [1:0] bresp,
	input logic bvalid,
	input logic bready,
	input logic arvalid,
	input logic arready,
	input logic [31:0] rdata,
	input logic rvalid,
	input logic rready,
	input logic [1:0] serial2_mode,
	input logic baud_double_active,
	input logic wdt_sys_reset,
	input logic irq
);
	// Every check runs on the one clock and sleeps while reset is low.
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// A read or write is taken when its handshakes meet at one edge.
	sequence s_rd_taken;
		arvalid && arready;
	endsequence
	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	AST_RD_LAT: assert property (s_rd_taken |-> ##2 rvalid) else $error("read answer late");
	AST_WR_LAT: assert property (s_wr_taken |-> ##3 bvalid) else $error("write answer late");
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	AST_R_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h0) else $error("upper bytes set");
	AST_AW_PULSE: assert property (awready |=> !awready) else $error("awready held");
	AST_BAUD_OFF: assert property (serial2_mode == 2'h0 |=> !baud_double_active)
		else $error("baud doubled in mode 0");
	AST_RST_PULSE: assert property (wdt_sys_reset |=> !wdt_sys_reset [*8])
		else $error("watchdog reset not a pulse");
	AST_POR_QUIET: assert property ($rose(aresetn) |-> !wdt_sys_reset && !irq)
		else $error("outputs active after power-on");
endmodule
bind wcu_top wcu_chk chk_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
	.rready(rready), .serial2_mode(serial2_mode), .baud_double_active(baud_double_active),
	.wdt_sys_reset(wdt_sys_reset), .irq(irq));

//--- verification/tb.sv
// Self-checking bench of the watchdog unit over its register bus.
`timescale 1ns/1ps
module tb;
	localparam int TO = 100; // Short interval keeps the run brief.
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic ext_reset_req = 0, power_fail_req = 0, timed_access_grant = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] serial2_mode = 0;
	wire awready, wready, bvalid, arready, rvalid, baud_double_active, wdt_sys_reset, irq;
	wire wdt_int_req, wdt_int_high_prio;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [3:0] ext_int_enable, ext_int_high_prio;
	int mismatches = 0, n_compared = 0, cyc = 0, wd, n;
	int unsigned s = 2, r;
	always #5 aclk = ~aclk;
	wcu_top #(.TIMEOUT_CYCLES(TO)) dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .ext_reset_req, .power_fail_req, .timed_access_grant,
		.serial2_mode, .baud_double_active, .wdt_sys_reset, .wdt_int_req, .wdt_int_high_prio,
		.ext_int_enable, .ext_int_high_prio, .irq);
	// Random source, fixed seed.
	function automatic int unsigned xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// One bus write; with g set, a grant pulse first opens the timed window.
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input bit g);
		bit pa, pw;
		if (g) begin
			timed_access_grant <= 1'h1;
			@(posedge aclk);
			timed_access_grant <= 1'h0;
		end
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		pa = 1;
		pw = 1;
		while (pa | pw) begin
			@(posedge aclk);
			if (awready) begin
				pa = 0;
				awvalid <= 1'h0;
			end
			if (wready) begin
				pw = 0;
				wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		chk(bresp, wcu_pkg::RESP_OKAY);
	endtask
	// Model of a control register write: without the window only bits 7 and 2 land.
	task automatic wdw(input logic [7:0] d, input bit g);
		wr(wcu_pkg::ADDR_WD_CTRL, d, g);
		wd = g ? (d & 8'hCE) : ((wd & 8'h4B) | (d & 8'h84));
	endtask
	task automatic rdr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge aclk); while (!rvalid);
		chk(rdata, e);
		chk(rresp, er);
	endtask
	// A hang is cut short here and reported as a failure.
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			final_report;
		end
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		wd = 'h40;
		rdr(wcu_pkg::ADDR_WD_CTRL, wd, 0);
		rdr(wcu_pkg::ADDR_INT_EN, 'hE0, 0);
		rdr(12'h0FC, 0, wcu_pkg::RESP_SLVERR);
		r = xs();
		serial2_mode <= 2'(r % 3 + 1);
		wdw('hFF, 0);
		rdr(wcu_pkg::ADDR_WD_CTRL, wd, 0);
		chk(baud_double_active, 1);
		// Mode zero is never doubled, even with the bit set.
		serial2_mode <= 2'h0;
		repeat (2) @(posedge aclk);
		chk(baud_double_active, 0);
		r = xs();
		wr(wcu_pkg::ADDR_INT_EN, 8'(r | 'h10), 0);
		rdr(wcu_pkg::ADDR_INT_EN, 'hF0 | (r & 'hF), 0);
		chk(ext_int_enable, r & 'hF);
		r = xs();
		wr(wcu_pkg::ADDR_INT_PRIO, 8'(r), 0);
		rdr(wcu_pkg::ADDR_INT_PRIO, r & 'h1F, 0);
		chk({wdt_int_high_prio, ext_int_high_prio}, r & 'h1F);
		wr(wcu_pkg::ADDR_IRQ_MASK, 'h3, 0);
		$display("test registers done");
		wdw('h03, 1);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!wdt_sys_reset);
		chk(n >= TO + 504 && n <= TO + 520, 1);
		wd = 'h0E;
		rdr(wcu_pkg::ADDR_WD_CTRL, wd, 0);
		rdr(wcu_pkg::ADDR_IRQ_STATUS, 3, 0);
		chk(irq, 1);
		wdw('h05, 1);
		wr(wcu_pkg::ADDR_IRQ_STATUS, 'h3, 0);
		rdr(wcu_pkg::ADDR_IRQ_STATUS, 0, 0);
		chk(irq, 0);
		$display("test timeout done");
		wdw('h84, 0);
		ext_reset_req <= 1'h1;
		@(posedge aclk);
		ext_reset_req <= 1'h0;
		wd &= wcu_pkg::EXT_RESET_KEEP;
		rdr(wcu_pkg::ADDR_WD_CTRL, wd, 0);
		power_fail_req <= 1'h1;
		@(posedge aclk);
		power_fail_req <= 1'h0;
		wd &= 'hFB;
		rdr(wcu_pkg::ADDR_WD_CTRL, wd, 0);
		$display("test resets done");
		n = 0;
		repeat (700) begin
			@(posedge aclk);
			if (wdt_sys_reset) n++;
		end
		chk(n, 0);
		wd |= 'h08;
		rdr(wcu_pkg::ADDR_WD_CTRL, wd, 0);
		chk(wdt_int_req, 1);
		$display("test no reset done");
		final_report;
	end
endmodule
